//--- logic/amfq_regs.vh
// amfq_regs.vh: register offsets, field positions, reset values and
// timing constants for the alert, mask and fault queue controller.
// assumes inclusion by the controller only; the fault queue counter does not include it.
`ifndef AMFQ_REGS_VH
`define AMFQ_REGS_VH

// ==========================================================
// register offsets
`define AMFQ_CFG1_ADDR 8'h01
`define AMFQ_CFG4_ADDR 8'h04
`define AMFQ_FQ_ADDR 8'h06
`define AMFQ_MASK1_ADDR 8'h08
`define AMFQ_MASK2_ADDR 8'h09
`define AMFQ_MASK3_ADDR 8'h0A
`define AMFQ_LHL_ADDR 8'h0B
`define AMFQ_LLL_ADDR 8'h0C
`define AMFQ_RHL_ADDR 8'h0E
`define AMFQ_RLL_ADDR 8'h0F
`define AMFQ_RATE_ADDR 8'h22
`define AMFQ_ST1_ADDR 8'h4F
`define AMFQ_ST2_ADDR 8'h50
`define AMFQ_ST3_ADDR 8'h51

// ==========================================================
// field positions and masks
`define AMFQ_CFG1_COMP_BIT 3
`define AMFQ_CFG4_REF_BIT 7
`define AMFQ_MASK1_USED 8'hF8
`define AMFQ_MASK2_USED 8'h1C
`define AMFQ_MASK3_USED 8'hC0
`define AMFQ_TSTATE_BIT 8'h04
`define AMFQ_RATE_MAX 8'h0A
`define AMFQ_RATE_NOAVG 4'h8

// ==========================================================
// reset values
`define AMFQ_CFG_RST 8'h00
`define AMFQ_FQ_RST 4'h0
`define AMFQ_MASK_RST 8'h00
`define AMFQ_HLIM_RST 8'h8B
`define AMFQ_LLIM_RST 8'h54
`define AMFQ_RATE_RST 8'h04
`define AMFQ_RATE_ACT_RST 4'h4

// ==========================================================
// timing: slowest conversion period and clock rate
`define AMFQ_MCLK_HZ 100000000
`define AMFQ_SLOW_PERIOD_MS 16000

`endif

//--- logic/amfq_fault_queue.v
// amfq_fault_queue.v: consecutive out-of-limit counter of one
// temperature channel.
// assumes one sample pulse per finished reading of this channel.
`timescale 1ns/1ps

module amfq_fault_queue (
   input wire clk,
   input wire rst_n,
   input wire ce,
   input wire sample,
   input wire out_of_limit,
   input wire clear,
   input wire [2:0] depth,
   output wire fill
);

reg [2:0] cnt_r;
reg [2:0] cnt_nxt;
reg [2:0] base;

// ==========================================================
// counting, saturating at four so it never wraps
always @*
begin
   base = clear ? 3'h0 : cnt_r; // (R16)
   cnt_nxt = base;
   if (sample)
   begin
      if (!out_of_limit)
         cnt_nxt = 3'h0; // (R13)
      else if (base != 3'h4)
         cnt_nxt = base + 3'h1;
   end
end

// fill fires on every reading that keeps the run at depth or beyond
assign fill = sample & out_of_limit & (cnt_nxt >= depth); // (R13)

// ==========================================================
// state
always @(posedge clk)
begin
   if (!rst_n)
      cnt_r <= 3'h0; // (R16)
   else if (ce)
      cnt_r <= cnt_nxt;
end

endmodule // amfq_fault_queue

//--- logic/amfq_ctrl.v
// amfq_ctrl.v: alert line, mask registers, status registers, fault
// queues, fan-fault pin and conversion-rate pacing of the monitor.
// assumes register port and event sources are logic on MCLK, so no
// synchronisers; the serial bus decoder drives the register strobes.
`timescale 1ns/1ps
`include "amfq_regs.vh"

// Behaviour
// (R1) config 1 bit 3 low selects latched alert, high comparator
// (R2) latched: out-of-limit sets status; unmasked source drives alert low
// (R3) latched alert holds until status read or alert response
// (R4) comparator alert follows unmasked out-of-limit sources, self clears
// (R5) mask suppresses alert only; status still sets
// (R6) mask 1 at 0x08 gates local, remote limits and diode error
// (R7) mask 2 at 0x09 gates thermal percent, limit and pin state
// (R8) thermal pin state mask ignored in comparator mode
// (R9) mask 3 at 0x0A gates fan stall and fan alarm speed
// (R10) fan-fault pin asserts on fan stall in fan-fault function
// (R11) pin is fan-fault after reset, reference when config 4 bit 7 set
// (R12) fault queue only on temperature channels, only in latched mode
// (R13) one queue per channel; alert after depth consecutive out readings
// (R14) depth from bits 3:0 of 0x06 gives 1, 2, 3 or 4
// (R15) queue counts regardless of status bits
// (R16) queues clear on alert response, status 1 read or reset
// (R17) queue clear releases alert; refill reasserts it
// (R18) rate codes 0x00 to 0x0A double from 1/16 to 64 per second
// (R19) averaging off at 16, 32 and 64 per second
// (R20) new rate applies only after the current loop finishes
// (R21) host masks serviced source and unmasks once status clears
// (R22) high limit flags at or above, low limit strictly below
// (R23) status bits sticky; read clears only once condition gone
// (R24) status 3 bit 0 reads one while alert is driven low
// (R25) other sources, and comparator mode, alert on first event
module amfq_ctrl #(
   parameter [31:0] CONV_BASE_CYC =
      `AMFQ_SLOW_PERIOD_MS * (`AMFQ_MCLK_HZ / 1000)
) (
   input wire MCLK,
   input wire RST_N,
   input wire CE,
   input wire [7:0] REG_ADDR,
   input wire [7:0] REG_WDATA,
   input wire REG_WR,
   input wire REG_RD,
   output wire [7:0] REG_RDATA,
   input wire ARA_DONE,
   input wire MEAS_VALID,
   input wire MEAS_CH,
   input wire [7:0] MEAS_VALUE,
   input wire REMOTE_DIODE_ERROR_SOURCE,
   input wire THERMAL_PCT_SOURCE,
   input wire THERMAL_LIMIT_ASSERT_SOURCE,
   input wire THERMAL_PIN_STATE_SOURCE,
   input wire FAN_STALL_SOURCE,
   input wire FAN_ALARM_SPEED_SOURCE,
   input wire LOOP_DONE,
   output wire ALERT_N,
   output wire FAN_FAULT_N,
   output wire REF_SEL,
   output wire CONV_START,
   output wire [3:0] RATE_CODE,
   output wire AVG_EN
);

// ==========================================================
// helpers
function [2:0] fq_depth;
   input [3:0] code;
   begin
      if (code[3])
         fq_depth = 3'h4; // (R14)
      else if (code[2])
         fq_depth = 3'h3;
      else if (code[1])
         fq_depth = 3'h2;
      else
         fq_depth = 3'h1;
   end
endfunction

// ==========================================================
// state
reg [7:0] cfg1_r;
reg [7:0] cfg4_r;
reg [3:0] fq_r;
reg [7:0] mask1_r;
reg [7:0] mask2_r;
reg [7:0] mask3_r;
reg [7:0] lhl_r;
reg [7:0] lll_r;
reg [7:0] rhl_r;
reg [7:0] rll_r;
reg [7:0] rate_req_r;
reg [3:0] rate_act_r;
reg avg_en_r;
reg [30:0] conv_cnt_r;
reg conv_start_r;
reg [3:0] tcur_r;
reg [7:0] st1_r;
reg [7:0] st2_r;
reg [7:0] st3_r;
reg [7:0] pend1_r;
reg [7:0] pend2_r;
reg [7:0] pend3_r;
reg alert_n_r;
reg fan_fault_n_r;
reg [7:0] rdata_r;

reg [7:0] st1_nxt;
reg [7:0] st2_nxt;
reg [7:0] st3_nxt;
reg [7:0] pend1_nxt;
reg [7:0] pend2_nxt;
reg [7:0] pend3_nxt;
reg [7:0] rd_mux;
reg alert_nxt;

wire comp_w = cfg1_r[`AMFQ_CFG1_COMP_BIT];
wire ref_w = cfg4_r[`AMFQ_CFG4_REF_BIT];
wire rd1_w = REG_RD & (REG_ADDR == `AMFQ_ST1_ADDR);
wire rd2_w = REG_RD & (REG_ADDR == `AMFQ_ST2_ADDR);
wire rd3_w = REG_RD & (REG_ADDR == `AMFQ_ST3_ADDR);
wire qclr_w = rd1_w | ARA_DONE;

// ==========================================================
// limit comparison of the reading in flight
wire [7:0] hlim_w = MEAS_CH ? rhl_r : lhl_r;
wire [7:0] llim_w = MEAS_CH ? rll_r : lll_r;
wire hi_w = MEAS_VALUE >= hlim_w; // (R22)
wire lo_w = MEAS_VALUE < llim_w; // (R22)
wire [3:0] upd_w = !MEAS_VALID ? 4'h0 : (MEAS_CH ? 4'h3 : 4'hC);
wire [3:0] ev_w = {hi_w, lo_w, hi_w, lo_w} & upd_w;
wire [3:0] tcur_nxt = (tcur_r & ~upd_w) | ev_w;

// ==========================================================
// one fault queue per temperature channel
wire fill_loc_w;
wire fill_rem_w;
wire [2:0] depth_w = fq_depth(fq_r);

amfq_fault_queue u_queue_local (
   .clk(MCLK),
   .rst_n(RST_N),
   .ce(CE),
   .sample(MEAS_VALID & ~MEAS_CH),
   .out_of_limit(hi_w | lo_w),
   .clear(qclr_w),
   .depth(depth_w),
   .fill(fill_loc_w)
); // (R13)

amfq_fault_queue u_queue_remote (
   .clk(MCLK),
   .rst_n(RST_N),
   .ce(CE),
   .sample(MEAS_VALID & MEAS_CH),
   .out_of_limit(hi_w | lo_w),
   .clear(qclr_w),
   .depth(depth_w),
   .fill(fill_rem_w)
); // (R13)

// which temperature source just filled its queue
wire [3:0] fill_w = {fill_loc_w & hi_w, fill_loc_w & lo_w,
   fill_rem_w & hi_w, fill_rem_w & lo_w};

// ==========================================================
// live conditions, laid out as the status bytes
wire [7:0] live1_w = {tcur_r, REMOTE_DIODE_ERROR_SOURCE, 3'h0};
wire [7:0] live2_w = {3'h0, THERMAL_PCT_SOURCE,
   THERMAL_LIMIT_ASSERT_SOURCE, THERMAL_PIN_STATE_SOURCE, 2'h0};
wire [7:0] live3_w = {FAN_STALL_SOURCE, FAN_ALARM_SPEED_SOURCE, 6'h0};
wire [7:0] set1_w = {ev_w, REMOTE_DIODE_ERROR_SOURCE, 3'h0};

// ==========================================================
// sticky status; a set in the clearing cycle wins
always @*
begin
   st1_nxt = (st1_r & (qclr_w ? live1_w : 8'hFF)) | set1_w; // (R23)
   st2_nxt = (st2_r & ((rd2_w | ARA_DONE) ? live2_w : 8'hFF))
      | live2_w; // (R23)
   st3_nxt = (st3_r & ((rd3_w | ARA_DONE) ? live3_w : 8'hFF))
      | live3_w; // (R5)
end

// ==========================================================
// latched alert sources; temperature ones only via the queue
always @*
begin
   pend1_nxt = (qclr_w ? 8'h00 : pend1_r)
      | ({fill_w, REMOTE_DIODE_ERROR_SOURCE, 3'h0} & ~mask1_r); // (R2)
   pend2_nxt = ((rd2_w | ARA_DONE) ? 8'h00 : pend2_r)
      | (live2_w & ~mask2_r); // (R25)
   pend3_nxt = ((rd3_w | ARA_DONE) ? 8'h00 : pend3_r)
      | (live3_w & ~mask3_r); // (R25)
   if (comp_w)
   begin
      // queue plays no part here, so nothing may stay latched
      pend1_nxt = 8'h00; // (R12)
      pend2_nxt = 8'h00;
      pend3_nxt = 8'h00;
   end
end

// ==========================================================
// alert level; masking later also releases a held source
always @*
begin
   if (comp_w)
      alert_nxt = |(live1_w & ~mask1_r) // (R4)
         | |(live2_w & ~(mask2_r & ~`AMFQ_TSTATE_BIT)) // (R8)
         | |(live3_w & ~mask3_r); // (R25)
   else
      alert_nxt = |(pend1_r & ~mask1_r) // (R3)
         | |(pend2_r & ~mask2_r) // (R17)
         | |(pend3_r & ~mask3_r); // (R5)
end

// ==========================================================
// read data; reserved bits read as zero
always @*
begin
   case (REG_ADDR)
      `AMFQ_CFG1_ADDR: rd_mux = cfg1_r;
      `AMFQ_CFG4_ADDR: rd_mux = cfg4_r;
      `AMFQ_FQ_ADDR: rd_mux = {4'h0, fq_r};
      `AMFQ_MASK1_ADDR: rd_mux = mask1_r;
      `AMFQ_MASK2_ADDR: rd_mux = mask2_r;
      `AMFQ_MASK3_ADDR: rd_mux = mask3_r;
      `AMFQ_LHL_ADDR: rd_mux = lhl_r;
      `AMFQ_LLL_ADDR: rd_mux = lll_r;
      `AMFQ_RHL_ADDR: rd_mux = rhl_r;
      `AMFQ_RLL_ADDR: rd_mux = rll_r;
      `AMFQ_RATE_ADDR: rd_mux = rate_req_r;
      `AMFQ_ST1_ADDR: rd_mux = st1_r;
      `AMFQ_ST2_ADDR: rd_mux = st2_r;
      `AMFQ_ST3_ADDR: rd_mux = {st3_r[7:1], ~alert_n_r}; // (R24)
      default: rd_mux = 8'h00;
   endcase
end

// ==========================================================
// register writes; reserved mask bits are never stored
always @(posedge MCLK)
begin
   if (!RST_N)
   begin
      cfg1_r <= `AMFQ_CFG_RST; // (R1)
      cfg4_r <= `AMFQ_CFG_RST; // (R11)
      fq_r <= `AMFQ_FQ_RST;
      mask1_r <= `AMFQ_MASK_RST;
      mask2_r <= `AMFQ_MASK_RST;
      mask3_r <= `AMFQ_MASK_RST;
      lhl_r <= `AMFQ_HLIM_RST;
      lll_r <= `AMFQ_LLIM_RST;
      rhl_r <= `AMFQ_HLIM_RST;
      rll_r <= `AMFQ_LLIM_RST;
      rate_req_r <= `AMFQ_RATE_RST;
      rdata_r <= 8'h00;
   end
   else if (CE)
   begin
      if (REG_RD)
         rdata_r <= rd_mux;
      if (REG_WR)
      begin
         case (REG_ADDR)
            `AMFQ_CFG1_ADDR: cfg1_r <= REG_WDATA; // (R1)
            `AMFQ_CFG4_ADDR: cfg4_r <= REG_WDATA; // (R11)
            `AMFQ_FQ_ADDR: fq_r <= REG_WDATA[3:0]; // (R14)
            `AMFQ_MASK1_ADDR: mask1_r <= REG_WDATA & `AMFQ_MASK1_USED; // (R6)
            `AMFQ_MASK2_ADDR: mask2_r <= REG_WDATA & `AMFQ_MASK2_USED; // (R7)
            `AMFQ_MASK3_ADDR: mask3_r <= REG_WDATA & `AMFQ_MASK3_USED; // (R9)
            `AMFQ_LHL_ADDR: lhl_r <= REG_WDATA;
            `AMFQ_LLL_ADDR: lll_r <= REG_WDATA;
            `AMFQ_RHL_ADDR: rhl_r <= REG_WDATA;
            `AMFQ_RLL_ADDR: rll_r <= REG_WDATA;
            `AMFQ_RATE_ADDR: rate_req_r <= REG_WDATA;
            default: ;
         endcase
      end
   end
end

// ==========================================================
// status, pending and alert flip-flops
always @(posedge MCLK)
begin
   if (!RST_N)
   begin
      tcur_r <= 4'h0;
      st1_r <= 8'h00;
      st2_r <= 8'h00;
      st3_r <= 8'h00;
      pend1_r <= 8'h00;
      pend2_r <= 8'h00;
      pend3_r <= 8'h00;
      alert_n_r <= 1'b1;
      fan_fault_n_r <= 1'b1;
   end
   else if (CE)
   begin
      tcur_r <= tcur_nxt;
      st1_r <= st1_nxt; // (R15)
      st2_r <= st2_nxt;
      st3_r <= st3_nxt;
      pend1_r <= pend1_nxt;
      pend2_r <= pend2_nxt;
      pend3_r <= pend3_nxt;
      alert_n_r <= ~alert_nxt; // (R2)
      // stall shown only while the pin has its fan-fault function
      fan_fault_n_r <= ~(FAN_STALL_SOURCE & ~ref_w); // (R10)
   end
end

// ==========================================================
// conversion pacing; a rate change waits for the loop boundary
// so one round-robin pass never mixes two rates
wire rate_ok_w = rate_req_r <= `AMFQ_RATE_MAX; // (R18)
wire [30:0] base_w = CONV_BASE_CYC[30:0];
wire [30:0] period_w = base_w >> rate_act_r; // (R18)
wire conv_due_w = conv_cnt_r >= (period_w - 31'h1);

always @(posedge MCLK)
begin
   if (!RST_N)
   begin
      rate_act_r <= `AMFQ_RATE_ACT_RST;
      avg_en_r <= 1'b1;
      conv_cnt_r <= 31'h0;
      conv_start_r <= 1'b0;
   end
   else if (CE)
   begin
      // reserved codes are kept for readback but never applied
      if (LOOP_DONE && rate_ok_w)
         rate_act_r <= rate_req_r[3:0]; // (R20)
      avg_en_r <= rate_act_r < `AMFQ_RATE_NOAVG; // (R19)
      conv_start_r <= conv_due_w;
      if (conv_due_w)
         conv_cnt_r <= 31'h0;
      else
         conv_cnt_r <= conv_cnt_r + 31'h1;
   end
end

// ==========================================================
// outputs, all from flip-flops
assign REG_RDATA = rdata_r;
assign ALERT_N = alert_n_r;
assign FAN_FAULT_N = fan_fault_n_r;
assign REF_SEL = cfg4_r[`AMFQ_CFG4_REF_BIT]; // (R11)
assign CONV_START = conv_start_r;
assign RATE_CODE = rate_act_r;
assign AVG_EN = avg_en_r;

endmodule // amfq_ctrl

//--- verification/amfq_ctrl_props.sv
// amfq_ctrl_props.sv: port checks of the alert controller.
// assumes default limits and that only the bench writes registers.
`timescale 1ns/1ps

module amfq_ctrl_props #(
   parameter [31:0] CONV_BASE_CYC = 32'd4096
) (
   input wire MCLK,
   input wire RST_N,
   input wire CE,
   input wire [7:0] REG_ADDR,
   input wire [7:0] REG_WDATA,
   input wire REG_WR,
   input wire REG_RD,
   input wire [7:0] REG_RDATA,
   input wire ARA_DONE,
   input wire MEAS_VALID,
   input wire MEAS_CH,
   input wire [7:0] MEAS_VALUE,
   input wire FAN_STALL_SOURCE,
   input wire LOOP_DONE,
   input wire ALERT_N,
   input wire FAN_FAULT_N,
   input wire REF_SEL,
   input wire [3:0] RATE_CODE,
   input wire AVG_EN
);
   reg [7:0] cfg1_r, fq_r, m1_r, m3_r, rate_r;
   wire wr_ok = CE && REG_WR;
   wire svc = (CE && REG_RD) || ARA_DONE || wr_ok;

   // ====
   // shadows of the registers that steer the alert path and the rate code
   always @(posedge MCLK)
      if (!RST_N)
      begin
         cfg1_r <= 8'h00;
         fq_r <= 8'h00;
         m1_r <= 8'h00;
         m3_r <= 8'h00;
         rate_r <= 8'h04;
      end
      else if (wr_ok)
         case (REG_ADDR)
            8'h01: cfg1_r <= REG_WDATA;
            8'h06: fq_r <= REG_WDATA;
            8'h08: m1_r <= REG_WDATA;
            8'h0A: m3_r <= REG_WDATA;
            8'h22: rate_r <= REG_WDATA;
            default: ;
         endcase

   // a hot local reading while latched with depth one and unmasked
   sequence hot_local_s;
      MEAS_VALID && CE && !MEAS_CH && MEAS_VALUE >= 8'h8B;
   endsequence
   sequence latched_d1_s;
      !cfg1_r[3] && fq_r[3:1] == 3'h0 && !m1_r[7];
   endsequence
   // a stall seen while the pin keeps its fault role
   sequence stall_s;
      CE && FAN_STALL_SOURCE && !REF_SEL ##1 !REF_SEL;
   endsequence

   fq1_alert_a: assert property (@(posedge MCLK) disable iff (!RST_N)
      hot_local_s and latched_d1_s |-> ##2 !ALERT_N)
      else $error("alert missing after hot reading");
   comp_fan_a: assert property (@(posedge MCLK) disable iff (!RST_N)
      cfg1_r[3] && !m3_r[7] && CE && FAN_STALL_SOURCE |=> !ALERT_N)
      else $error("comparator alert missing");
   lat_hold_a: assert property (@(posedge MCLK) disable iff (!RST_N)
      !cfg1_r[3] && $rose(ALERT_N) |-> $past(svc) || $past(svc, 2))
      else $error("latched alert released unserviced");
   st3_alert_a: assert property (@(posedge MCLK) disable iff (!RST_N)
      CE && REG_RD && REG_ADDR == 8'h51 |=> REG_RDATA[0] == !$past(ALERT_N))
      else $error("status 3 alert bit wrong");
   ref_sel_a: assert property (@(posedge MCLK) disable iff (!RST_N)
      wr_ok && REG_ADDR == 8'h04 && REG_WDATA[7] |=> REF_SEL)
      else $error("pin role not switched");
   fan_fault_a: assert property (@(posedge MCLK) disable iff (!RST_N)
      stall_s |-> !FAN_FAULT_N)
      else $error("fan fault not driven");
   rate_apply_a: assert property (@(posedge MCLK) disable iff (!RST_N)
      LOOP_DONE && CE && rate_r <= 8'h0A |=>
      RATE_CODE == $past(rate_r[3:0]))
      else $error("rate code not applied");
   rate_hold_a: assert property (@(posedge MCLK) disable iff (!RST_N)
      $past(RST_N) && !$stable(RATE_CODE) |-> $past(LOOP_DONE))
      else $error("rate code changed mid loop");
   avg_code_a: assert property (@(posedge MCLK) disable iff (!RST_N)
      $stable(RATE_CODE) |-> AVG_EN == (RATE_CODE < 4'h8))
      else $error("averaging enable wrong");
endmodule // amfq_ctrl_props

bind amfq_ctrl amfq_ctrl_props #(.CONV_BASE_CYC(CONV_BASE_CYC)) i_props (
   .MCLK(MCLK), .RST_N(RST_N), .CE(CE), .REG_ADDR(REG_ADDR),
   .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
   .REG_RDATA(REG_RDATA), .ARA_DONE(ARA_DONE), .MEAS_VALID(MEAS_VALID),
   .MEAS_CH(MEAS_CH), .MEAS_VALUE(MEAS_VALUE), .LOOP_DONE(LOOP_DONE),
   .FAN_STALL_SOURCE(FAN_STALL_SOURCE), .ALERT_N(ALERT_N),
   .FAN_FAULT_N(FAN_FAULT_N), .REF_SEL(REF_SEL), .RATE_CODE(RATE_CODE),
   .AVG_EN(AVG_EN));

//--- verification/amfq_host_model.sv
// amfq_host_model.sv: host that answers a low alert line with an
// alert response cycle; register traffic stays with the bench.
`timescale 1ns/1ps

module amfq_host_model (
   input wire mclk,
   input wire alert_n,
   input wire en,
   input wire [3:0] dly,
   output reg ara_done
);
   reg [3:0] cnt = 4'h0;

   // ====
   // service: wait dly cycles, then one response pulse; a slow host
   // shows whether the line holds low in the meantime
   initial
      ara_done = 1'b0;
   always @(negedge mclk)
      if (!en || alert_n || ara_done)
      begin
         cnt <= 4'h0;
         ara_done <= 1'b0;
      end
      else if (cnt == dly)
         ara_done <= 1'b1;
      else
         cnt <= cnt + 4'h1;
endmodule // amfq_host_model

//--- verification/test_amfq_ctrl.sv
// test_amfq_ctrl.sv: self-checking bench of the alert controller.
// assumes the controller, the host model and the bound checker.
`timescale 1ns/1ps

module test_amfq_ctrl;
   reg mclk, rst_n, ce, reg_wr, reg_rd, meas_valid, meas_ch, loop_done;
   reg host_en;
   reg [3:0] host_dly;
   reg [5:0] src;
   reg [7:0] reg_addr, reg_wdata, meas_value, e;
   wire ara_done, alert_n, fan_fault_n, ref_sel, avg_en, conv_start;
   wire [7:0] reg_rdata;
   wire [3:0] rate_code;
   integer n_fail, n_tests, i, j;

   amfq_ctrl #(.CONV_BASE_CYC(32'd4096)) i_amfq_ctrl (
      .MCLK(mclk), .RST_N(rst_n), .CE(ce), .REG_ADDR(reg_addr),
      .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
      .REG_RDATA(reg_rdata), .ARA_DONE(ara_done), .MEAS_VALID(meas_valid),
      .MEAS_CH(meas_ch), .MEAS_VALUE(meas_value),
      .REMOTE_DIODE_ERROR_SOURCE(src[0]), .THERMAL_PCT_SOURCE(src[1]),
      .THERMAL_LIMIT_ASSERT_SOURCE(src[2]),
      .THERMAL_PIN_STATE_SOURCE(src[3]), .FAN_STALL_SOURCE(src[4]),
      .FAN_ALARM_SPEED_SOURCE(src[5]), .LOOP_DONE(loop_done),
      .ALERT_N(alert_n), .FAN_FAULT_N(fan_fault_n), .REF_SEL(ref_sel),
      .CONV_START(conv_start), .RATE_CODE(rate_code), .AVG_EN(avg_en));
   amfq_host_model i_amfq_host_model (.mclk(mclk), .alert_n(alert_n),
      .en(host_en), .dly(host_dly), .ara_done(ara_done));

   // ====
   // shared drivers; inputs move on the falling edge only
   task chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests = n_tests + 1;
      if (got !== exp)
      begin
         n_fail = n_fail + 1;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task wr(input [7:0] a, input [7:0] v);
      @(negedge mclk);
      reg_addr = a;
      reg_wdata = v;
      reg_wr = 1'b1;
      @(negedge mclk);
      reg_wr = 1'b0;
   endtask
   task rd(input [7:0] a, input [7:0] x);
      @(negedge mclk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge mclk);
      reg_rd = 1'b0;
      @(negedge mclk);
      chk(reg_rdata, x);
   endtask
   // reset value, then all ones to expose the writable bits
   task wrd(input [7:0] a, input [7:0] x);
      rd(a, 8'h00);
      wr(a, 8'hFF);
      rd(a, x);
      wr(a, 8'h00);
   endtask
   task meas(input c, input [7:0] v);
      @(negedge mclk);
      meas_ch = c;
      meas_value = v;
      meas_valid = 1'b1;
      @(negedge mclk);
      meas_valid = 1'b0;
   endtask
   // two edges cover the pending stage plus the line register
   task alert(input x);
      repeat (2) @(negedge mclk);
      chk({7'h00, alert_n}, {7'h00, x});
   endtask

   // ====
   // scenarios
   task t_regs;
      rd(8'h22, 8'h04);
      wrd(8'h06, 8'h0F);
      wrd(8'h08, 8'hF8);
      wrd(8'h09, 8'h1C);
      wrd(8'h0A, 8'hC0);
      wrd(8'h7F, 8'h00);
   endtask
   task t_latch;
      meas(0, 8'h54);
      alert(1);
      meas(0, 8'h8B);
      alert(0);
      meas(0, 8'h60);
      alert(0);
      rd(8'h51, 8'h01);
      rd(8'h4F, 8'h80);
      alert(1);
      meas(0, 8'h53);
      alert(0);
      meas(0, 8'h60);
      rd(8'h4F, 8'h40);
      alert(1);
   endtask
   task t_mask;
      wr(8'h08, 8'h80);
      meas(0, 8'h90);
      alert(1);
      meas(1, 8'h90);
      alert(0);
      meas(0, 8'h60);
      meas(1, 8'h60);
      rd(8'h4F, 8'hA0);
      alert(1);
      wr(8'h08, 8'h00);
   endtask
   // depth three; an in-limit reading breaks the run of faults
   task t_queue;
      wr(8'h06, 8'h04);
      meas(0, 8'h90);
      meas(0, 8'h90);
      meas(0, 8'h60);
      meas(0, 8'h90);
      meas(0, 8'h90);
      alert(1);
      meas(0, 8'h90);
      alert(0);
      rd(8'h4F, 8'h80);
      alert(1);
      meas(0, 8'h90);
      meas(1, 8'h60);
      meas(0, 8'h90);
      alert(1);
      meas(0, 8'h90);
      alert(0);
      meas(0, 8'h60);
      rd(8'h4F, 8'h80);
      alert(1);
      wr(8'h06, 8'h00);
   endtask
   // a prompt host, then a slow one
   task t_ara;
      for (i = 0; i < 2; i = i + 1)
      begin
         host_dly = (i == 0) ? 4'h0 : 4'h8;
         src = 6'h20;
         @(negedge mclk);
         src = 6'h00;
         alert(0);
         alert(0);
         host_en = 1'b1;
         for (j = 0; j < 20 && alert_n !== 1'b1; j = j + 1)
            @(negedge mclk);
         host_en = 1'b0;
         chk({7'h00, alert_n}, 8'h01);
         // the line may only rise after the host's response delay
         chk({7'h00, j > host_dly}, 8'h01);
      end
   endtask
   // host service: read, mask the source, poll, unmask once clear
   task t_serv;
      src = 6'h10;
      alert(0);
      rd(8'h51, 8'h81);
      wr(8'h0A, 8'h80);
      alert(1);
      src = 6'h00;
      rd(8'h51, 8'h80);
      rd(8'h51, 8'h00);
      wr(8'h0A, 8'h00);
      alert(1);
   endtask
   task t_comp;
      wr(8'h01, 8'h08);
      wr(8'h09, 8'h04);
      wr(8'h06, 8'h04);
      for (i = 0; i < 6; i = i + 1)
      begin
         src = 6'h01 << i;
         alert(0);
         src = 6'h00;
         alert(1);
      end
      wr(8'h0A, 8'hC0);
      src = 6'h30;
      alert(1);
      src = 6'h00;
      meas(0, 8'h90);
      alert(0);
      meas(0, 8'h60);
      alert(1);
      wr(8'h0A, 8'h00);
      wr(8'h01, 8'h00);
      wr(8'h06, 8'h00);
   endtask
   task t_fan;
      chk({6'h00, ref_sel, fan_fault_n}, 8'h01);
      src = 6'h10;
      repeat (2) @(negedge mclk);
      chk({6'h00, ref_sel, fan_fault_n}, 8'h00);
      wr(8'h04, 8'h80);
      @(negedge mclk);
      chk({6'h00, ref_sel, fan_fault_n}, 8'h03);
      src = 6'h00;
      wr(8'h04, 8'h00);
   endtask
   // codes take effect only at the end of a loop; 0x0B is ignored
   task t_rate;
      e = 8'h04;
      for (i = 7; i < 12; i = i + 1)
      begin
         wr(8'h22, i[7:0]);
         repeat (2) @(negedge mclk);
         chk({4'h0, rate_code}, e);
         loop_done = 1'b1;
         @(negedge mclk);
         loop_done = 1'b0;
         if (i < 11)
            e = i[7:0];
         @(negedge mclk);
         chk({3'h0, avg_en, rate_code}, {3'h0, e < 8'h08, e[3:0]});
      end
      // code 0x0A: one start every base/1024 cycles, four with base 4096
      for (j = 0; j < 8 && conv_start !== 1'b1; j = j + 1)
         @(negedge mclk);
      @(negedge mclk);
      for (j = 1; j < 20 && conv_start !== 1'b1; j = j + 1)
         @(negedge mclk);
      chk(j[7:0], 8'h04);
   endtask
   // reset in mid-run drops the latched alert and the reserved code
   task t_reset;
      rst_n = 1'b0;
      repeat (2) @(negedge mclk);
      rst_n = 1'b1;
      chk({rate_code, avg_en, ref_sel, fan_fault_n, alert_n}, 8'h4B);
      rd(8'h51, 8'h00);
      rd(8'h22, 8'h04);
   endtask

   task end_sim;
      if (n_fail == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // ====
   // clock, watchdog and main sequence
   initial
   begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   initial
   begin
      #500000;
      n_fail = n_fail + 1;
      end_sim;
   end
   initial
   begin
      {rst_n, reg_wr, reg_rd, meas_valid, meas_ch, loop_done} = 6'h00;
      {host_en, host_dly, src, reg_addr, reg_wdata, meas_value} = 0;
      ce = 1'b1;
      n_fail = 0;
      n_tests = 0;
      repeat (10) @(negedge mclk);
      rst_n = 1'b1;
      t_regs;
      t_latch;
      t_mask;
      t_queue;
      t_ara;
      t_serv;
      t_comp;
      t_fan;
      t_rate;
      t_reset;
      end_sim;
   end
endmodule // test_amfq_ctrl
